// >>> src/cps_core_seq.sv
// Notes on behaviour
// [RQ1] Secure mode comes only from one external input; restrictions apply while it is high.
// [RQ2] RAM, flash, EEPROM are secure; direct-page and high-page registers are non-secure.
// [RQ3] Every program fetch is tagged secure or non-secure by its source memory.
// [RQ4] Secure-mode data read of secure memory gives zero for non-secure code or debug.
// [RQ5] Secure-mode write to secure memory is dropped for non-secure code or debug.
// [RQ6] Stacking writes during interrupt entry are never dropped.
// [RQ7] Code tagged secure reads and writes all memory freely.
// [RQ8] Debug port accesses to non-secure memory are always allowed.
// [RQ9] With secure mode off, every access is allowed.
// [RQ10] Any reset event abandons the current operation at once.
// [RQ11] Reset ends only when source detection is done and the reset pin is released.
// [RQ12] After reset, six cycles fetch the reset vector bytes and fill the queue.
// [RQ13] Interrupts are taken only at an instruction boundary, return point is next instruction.
// [RQ14] Vector comes from the highest pending interrupt at entry, else soft trap sequence; the code takes the soft trap vector whenever a trap is requested.
// [RQ15] Entry pushes PC low, PC high, X, A, flags in that order.
// [RQ16] The interrupt mask is set once the flags register is stacked.
// [RQ17] Then vector high, vector low, one free cycle, three program fetches.
// [RQ18] The upper index byte is not stacked.
// [RQ19] The soft trap runs the same entry at a boundary and ignores the mask.
// [RQ20] Interrupt logic holds its vector stable from entry until both vector bytes are read.
`timescale 1ns/1ps
module cps_core_seq (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Security and reset sources
   input  wire logic        secure_mode_in,
   input  wire logic        reset_pin_n,
   input  wire logic        por_event,
   input  wire logic        watchdog_timer_reset,
   input  wire logic        reset_source_done,
   // Core state and requests
   input  wire logic        instr_boundary,
   input  wire logic        soft_trap_instruction,
   input  wire logic        irq_pending,
   input  wire logic [15:0] irq_vector_addr,
   input  wire logic [15:0] core_pc,
   input  wire logic [15:0] core_sp,
   input  wire logic [7:0]  core_x,
   input  wire logic [7:0]  core_a,
   input  wire logic [7:0]  condition_flags_register,
   // Core memory access
   input  wire logic        acc_valid,
   input  wire logic        acc_write,
   input  wire logic        acc_fetch,
   input  wire logic        acc_opcode,
   input  wire logic        acc_debug,
   input  wire logic [15:0] acc_addr,
   input  wire logic [7:0]  acc_wdata,
   output logic [7:0]       cpu_rdata,
   output logic             cpu_rvalid,
   output logic             cpu_rtag_secure,
   // Memory arrays
   output logic             mem_req,
   output logic             mem_we,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   input  wire logic        mem_rvalid,
   input  wire logic [7:0]  mem_rdata,
   // Sequencer results
   output logic             core_hold,
   output logic             set_imask,
   output logic             pc_load,
   output logic [15:0]      pc_load_value
);
   import cps_pkg::*;

   cps_state_t  state, next_state;
   logic        sec_s1, sec_s2, pin_s1, pin_s2;
   logic        irq_entry, instr_secure, irq_en;
   logic [15:0] vec_base, fetch_ptr, block_cnt, last_vec;
   logic [7:0]  vec_hi;
   logic        rd_blk_q, rd_tag_q, rd_blk_q2, rd_tag_q2, rd_q;
   logic        reset_event, take_irq, take_trap;
   logic        next_req, next_we, next_fetch, next_opc, next_dbg, next_stack;
   logic [15:0] next_addr;
   logic [7:0]  next_wdata;
   logic        region, deny_rd, deny_wr, denied;

   // Pin synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_s1 <= 1'b0;
         sec_s2 <= 1'b0;
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
      end else begin
         sec_s1 <= secure_mode_in;
         sec_s2 <= sec_s1;       // [RQ1]
         pin_s1 <= reset_pin_n;
         pin_s2 <= pin_s1;
      end
   end

   assign reset_event = por_event | watchdog_timer_reset | ~pin_s2;
   assign take_trap   = instr_boundary & soft_trap_instruction;                              // [RQ19]
   assign take_irq    = instr_boundary & irq_pending & irq_en & ~condition_flags_register[FLG_I_BIT]; // [RQ13]

   // Sequencer state
   always_comb begin
      next_state = state;
      case (state)
         CPS_RESET: if (!reset_event && reset_source_done) next_state = CPS_VHI;  // [RQ11]
         CPS_RUN:   if (take_trap || take_irq) next_state = CPS_PLO;
         CPS_PLO:   next_state = CPS_PHI;
         CPS_PHI:   next_state = CPS_XL;
         CPS_XL:    next_state = CPS_ACC;
         CPS_ACC:   next_state = CPS_FLG;
         CPS_FLG:   next_state = CPS_VHI;
         CPS_VHI:   next_state = CPS_VLO;
         CPS_VLO:   next_state = CPS_FREE;
         CPS_FREE:  next_state = CPS_Q1;
         CPS_Q1:    next_state = CPS_Q2;
         CPS_Q2:    next_state = CPS_Q3;
         CPS_Q3:    next_state = CPS_RUN;
         default:   next_state = CPS_RESET;
      endcase
      if (reset_event) next_state = CPS_RESET;                                    // [RQ10]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state     <= CPS_RESET;
         core_hold <= 1'b1;
         irq_entry <= 1'b0;
         vec_base  <= RESET_VEC;
         set_imask <= 1'b0;
      end else begin
         state     <= next_state;
         core_hold <= (next_state != CPS_RUN);
         set_imask <= (state == CPS_FLG) && !reset_event;                         // [RQ16]
         if (state == CPS_RESET) begin
            irq_entry <= 1'b0;
            vec_base  <= RESET_VEC;
         end else if (state == CPS_RUN && next_state == CPS_PLO) begin
            irq_entry <= 1'b1;
            vec_base  <= take_trap ? SOFT_TRAP_VEC : irq_vector_addr;             // [RQ14]
         end
      end
   end

   // Access source and security gating
   always_comb begin
      next_req   = 1'b0;
      next_we    = 1'b0;
      next_fetch = 1'b0;
      next_opc   = 1'b0;
      next_dbg   = 1'b0;
      next_stack = 1'b0;
      next_addr  = 16'h0000;
      next_wdata = 8'h00;
      case (state)
         CPS_PLO, CPS_PHI, CPS_XL, CPS_ACC, CPS_FLG: begin
            next_req   = 1'b1;
            next_we    = 1'b1;
            next_stack = 1'b1;
            // Upper index byte deliberately not pushed  [RQ18]
            case (state)
               CPS_PLO: {next_addr, next_wdata} = {core_sp, core_pc[7:0]};                       // [RQ15]
               CPS_PHI: {next_addr, next_wdata} = {core_sp - 16'h0001, core_pc[15:8]};
               CPS_XL:  {next_addr, next_wdata} = {core_sp - 16'h0002, core_x};
               CPS_ACC: {next_addr, next_wdata} = {core_sp - 16'h0003, core_a};
               default: {next_addr, next_wdata} = {core_sp - 16'h0004, condition_flags_register};
            endcase
         end
         CPS_VHI: begin
            next_req   = 1'b1;
            next_fetch = 1'b1;
            next_addr  = vec_base;                                                // [RQ12]
         end
         CPS_VLO: begin
            next_req   = 1'b1;
            next_fetch = 1'b1;
            next_addr  = vec_base + 16'h0001;                                     // [RQ17]
         end
         CPS_Q1: begin
            next_req   = 1'b1;
            next_fetch = 1'b1;
            next_opc   = 1'b1;
            next_addr  = {vec_hi, mem_rdata};
         end
         CPS_Q2, CPS_Q3: begin
            next_req   = 1'b1;
            next_fetch = 1'b1;
            next_addr  = fetch_ptr;
         end
         CPS_RUN: begin
            next_req   = acc_valid;
            next_we    = acc_write;
            next_fetch = acc_fetch & ~acc_write;
            next_opc   = acc_opcode;
            next_dbg   = acc_debug;
            next_addr  = acc_addr;
            next_wdata = acc_wdata;
         end
         default: next_req = 1'b0;
      endcase
      region  = !((next_addr >= DIRECT_REG_LO && next_addr <= DIRECT_REG_HI) ||
                  (next_addr >= HIGH_REG_LO && next_addr <= HIGH_REG_HI));        // [RQ2]
      // Secure mode off leaves every access open  [RQ9]
      // Secure code and debug to register space pass  [RQ7] [RQ8]
      deny_rd = sec_s2 && region && !next_fetch && (!instr_secure || next_dbg);   // [RQ4]
      deny_wr = sec_s2 && region && !next_stack && (!instr_secure || next_dbg);   // [RQ5] [RQ6]
      denied  = next_req && (next_we ? deny_wr : deny_rd);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= 16'h0000;
         mem_wdata <= 8'h00;
         rd_q      <= 1'b0;
         rd_blk_q  <= 1'b0;
         rd_tag_q  <= 1'b0;
      end else begin
         // Blocked write never reaches the array; blocked read is masked on return
         mem_req   <= next_req && !(next_we && deny_wr);
         mem_we    <= next_req && next_we && !deny_wr;
         mem_addr  <= next_addr;
         mem_wdata <= next_wdata;
         rd_q      <= next_req && !next_we;
         rd_blk_q  <= deny_rd;
         rd_tag_q  <= region;                                                     // [RQ3]
      end
   end

   // Current instruction tag, vector capture, queue pointer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_secure <= 1'b0;
         vec_hi       <= 8'h00;
         fetch_ptr    <= 16'h0000;
      end else begin
         if (next_req && next_fetch && next_opc) instr_secure <= region;         // [RQ3]
         if (state == CPS_FREE && mem_rvalid) vec_hi <= mem_rdata;
         if (state == CPS_Q1) fetch_ptr <= {vec_hi, mem_rdata} + 16'h0001;
         else if (state == CPS_Q2) fetch_ptr <= fetch_ptr + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_blk_q2       <= 1'b0;
         rd_tag_q2       <= 1'b0;
         cpu_rvalid      <= 1'b0;
         cpu_rdata       <= 8'h00;
         cpu_rtag_secure <= 1'b0;
         pc_load         <= 1'b0;
         pc_load_value   <= 16'h0000;
      end else begin
         rd_blk_q2       <= rd_blk_q && rd_q;
         rd_tag_q2       <= rd_tag_q;
         cpu_rvalid      <= mem_rvalid;
         cpu_rdata       <= rd_blk_q2 ? BLOCKED_DATA : mem_rdata;                 // [RQ4]
         cpu_rtag_secure <= rd_tag_q2;
         pc_load         <= (state == CPS_Q1) && !reset_event;
         if (state == CPS_Q1) pc_load_value <= {vec_hi, mem_rdata};
      end
   end

   // AXI4-Lite slave
   logic        aw_held, w_held;
   logic [7:0]  aw_q;
   logic [31:0] w_q;
   logic [3:0]  ws_q;
   logic        do_wr, clr_cnt;
   assign do_wr   = aw_held && w_held && !s_axi_bvalid;
   assign clr_cnt = do_wr && aw_q == OFS_BLOCK_CNT && ws_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_q          <= 8'h00;
         w_q           <= 32'h0000_0000;
         ws_q          <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         irq_en        <= CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_q          <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_q          <= s_axi_wdata;
            ws_q         <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_q == OFS_CTRL || aw_q == OFS_BLOCK_CNT) ? RESP_OKAY : RESP_SLVERR;
            if (aw_q == OFS_CTRL && ws_q[0]) irq_en <= w_q[CTRL_IRQ_EN];
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL:      s_axi_rdata <= {31'h0, irq_en};
            OFS_STATUS:    s_axi_rdata <= {24'h0, state, core_hold, irq_entry, instr_secure, sec_s2};
            OFS_BLOCK_CNT: s_axi_rdata <= {16'h0, block_cnt};
            OFS_LAST_VEC:  s_axi_rdata <= {16'h0, last_vec};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Blocked-access counter: a clear and a new block in the same cycle leave a count of one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_cnt <= 16'h0000;
         last_vec  <= 16'h0000;
      end else begin
         if (denied) block_cnt <= (clr_cnt ? 16'h0000 : block_cnt) + 16'h0001;
         else if (clr_cnt) block_cnt <= 16'h0000;
         if (state == CPS_Q1) last_vec <= {vec_hi, mem_rdata};
      end
   end

   // Checks
   property p_rd_zero;
      @(posedge aclk) disable iff (!aresetn) mem_rvalid && rd_blk_q2 |=> cpu_rvalid && cpu_rdata == BLOCKED_DATA;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("blocked read returned data"); // [RQ4]
   property p_wr_block;
      @(posedge aclk) disable iff (!aresetn)
         state == CPS_RUN && !reset_event && acc_valid && acc_write && deny_wr |=> !mem_we;
   endproperty
   a_wr_block: assert property (p_wr_block) else $error("blocked write reached memory"); // [RQ5]
   property p_stack_wr;
      @(posedge aclk) disable iff (!aresetn || reset_event)
         state == CPS_PLO |=> mem_we [*5];
   endproperty
   a_stack_wr: assert property (p_stack_wr) else $error("stacking write dropped"); // [RQ6]
   property p_sec_code;
      @(posedge aclk) disable iff (!aresetn)
         state == CPS_RUN && acc_valid && acc_write && instr_secure && !acc_debug |=> mem_we;
   endproperty
   a_sec_code: assert property (p_sec_code) else $error("secure code write dropped"); // [RQ7]
   property p_dbg_ns;
      @(posedge aclk) disable iff (!aresetn)
         state == CPS_RUN && acc_valid && acc_debug && !region |=> mem_req && mem_addr == $past(acc_addr);
   endproperty
   a_dbg_ns: assert property (p_dbg_ns) else $error("debug access to register space blocked"); // [RQ8]
   property p_open;
      @(posedge aclk) disable iff (!aresetn) !sec_s2 |-> !denied;
   endproperty
   a_open: assert property (p_open) else $error("access denied outside secure mode"); // [RQ9]
   property p_abort;
      @(posedge aclk) disable iff (!aresetn) reset_event |=> state == CPS_RESET && core_hold;
   endproperty
   a_abort: assert property (p_abort) else $error("reset did not abort"); // [RQ10]
   property p_reset_end;
      @(posedge aclk) disable iff (!aresetn) state == CPS_RESET && !reset_source_done |=> state == CPS_RESET;
   endproperty
   a_reset_end: assert property (p_reset_end) else $error("reset left early"); // [RQ11]
   property p_rst_vec;
      @(posedge aclk) disable iff (!aresetn)
         state == CPS_VHI && !irq_entry && !reset_event |=> mem_addr == RESET_VEC ##1 mem_addr == RESET_VEC + 16'h0001;
   endproperty
   a_rst_vec: assert property (p_rst_vec) else $error("reset vector address wrong"); // [RQ12]
   property p_order;
      @(posedge aclk) disable iff (!aresetn || reset_event)
         state == CPS_PLO |=> mem_wdata == $past(core_pc[7:0]) ##1 state == CPS_XL ##1 state == CPS_ACC
         ##1 state == CPS_FLG ##1 mem_wdata == $past(condition_flags_register);
   endproperty
   a_order: assert property (p_order) else $error("stacking order wrong"); // [RQ15]
   property p_tail;
      @(posedge aclk) disable iff (!aresetn || reset_event)
         state == CPS_FLG |=> set_imask && state == CPS_VHI ##3 state == CPS_Q1 ##3 !core_hold;
   endproperty
   a_tail: assert property (p_tail) else $error("entry tail wrong"); // [RQ16] [RQ17]
   property p_trap;
      @(posedge aclk) disable iff (!aresetn)
         state == CPS_RUN && !reset_event && take_trap |=> state == CPS_PLO && vec_base == SOFT_TRAP_VEC;
   endproperty
   a_trap: assert property (p_trap) else $error("soft trap not taken"); // [RQ19]
endmodule : cps_core_seq

// >>> src/cps_pkg.sv
package cps_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_STATUS     = 8'h04;
   localparam logic [7:0]  OFS_BLOCK_CNT  = 8'h08;
   localparam logic [7:0]  OFS_LAST_VEC   = 8'h0c;
   localparam int          CTRL_IRQ_EN    = 0;
   localparam logic        CTRL_RESET     = 1'b1;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
   // Non-secure register windows
   localparam logic [15:0] DIRECT_REG_LO  = 16'h0000;
   localparam logic [15:0] DIRECT_REG_HI  = 16'h003f;
   localparam logic [15:0] HIGH_REG_LO    = 16'h1800;
   localparam logic [15:0] HIGH_REG_HI    = 16'h18ff;
   // Vectors
   localparam logic [15:0] RESET_VEC      = 16'hfffe;
   localparam logic [15:0] SOFT_TRAP_VEC  = 16'hfffc;
   localparam int          FLG_I_BIT      = 3;
   localparam logic [7:0]  BLOCKED_DATA   = 8'h00;

   typedef enum logic [3:0] {
      CPS_RESET, CPS_RUN, CPS_PLO, CPS_PHI, CPS_XL, CPS_ACC, CPS_FLG,
      CPS_VHI, CPS_VLO, CPS_FREE, CPS_Q1, CPS_Q2, CPS_Q3
   } cps_state_t;
endpackage : cps_pkg

// >>> verif/cps_mem_model.sv
`timescale 1ns/1ps
module cps_mem_model (
   // Clock
   input  wire logic        aclk,
   // Request from the block
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   // Answer to the block
   output logic             mem_rvalid,
   output logic [7:0]       mem_rdata
);
   logic [7:0] mem [0:65535];

   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
      mem_rvalid = 1'b0;
      mem_rdata  = 8'h00;
   end

   // Read answer exactly one cycle after the request; data toggles when idle
   always @(posedge aclk) begin
      mem_rvalid <= mem_req && !mem_we;
      if (mem_req && mem_we) mem[mem_addr] <= mem_wdata;
      mem_rdata <= (mem_req && !mem_we) ? mem[mem_addr] : ~mem_rdata;
   end
endmodule : cps_mem_model

// >>> verif/cps_core_seq_bench.sv
`timescale 1ns/1ps
module cps_core_seq_bench;
   import cps_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, core_x, core_a, condition_flags_register, acc_wdata;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        secure_mode_in, reset_pin_n, por_event, watchdog_timer_reset, reset_source_done;
   logic        instr_boundary, soft_trap_instruction, irq_pending, sm, tg, dbg, rg, ok;
   logic [15:0] irq_vector_addr, core_pc, core_sp, acc_addr, mem_addr, pc_load_value, ad, fa, lastv;
   logic        acc_valid, acc_write, acc_fetch, acc_opcode, acc_debug;
   logic [7:0]  cpu_rdata, mem_wdata, mem_rdata, rnd, old;
   logic        cpu_rvalid, cpu_rtag_secure, mem_req, mem_we, mem_rvalid, core_hold, set_imask, pc_load;
   logic [33:0] e;
   logic [33:0] rd_q[$], ax_q[$], pc_q[$];
   int          error_cnt, compares, cycles, denies, imasks;

   cps_core_seq dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .secure_mode_in, .reset_pin_n,
      .por_event, .watchdog_timer_reset, .reset_source_done, .instr_boundary, .soft_trap_instruction, .irq_pending,
      .irq_vector_addr, .core_pc, .core_sp, .core_x, .core_a, .condition_flags_register, .acc_valid, .acc_write,
      .acc_fetch, .acc_opcode, .acc_debug, .acc_addr, .acc_wdata, .cpu_rdata, .cpu_rvalid, .cpu_rtag_secure,
      .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rvalid, .mem_rdata, .core_hold, .set_imask, .pc_load,
      .pc_load_value);
   cps_mem_model u_mem (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rvalid, .mem_rdata);

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // Results are matched against the oldest note of their kind
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         end_of_test();
      end
      if (set_imask === 1'b1) imasks++;
      if (cpu_rvalid === 1'b1) begin
         e = rd_q.size() ? rd_q.pop_front() : 'x;
         chk({25'h0, e[9] & cpu_rtag_secure, cpu_rdata}, {25'h0, e[9] & e[8], e[7:0]});
      end
      if (pc_load === 1'b1) chk(34'(pc_load_value), pc_q.size() ? pc_q.pop_front() : 'x);
      if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, ax_q.size() ? ax_q.pop_front() : 'x);
      if (s_axi_bvalid === 1'b1 && s_axi_bready) chk({s_axi_bresp, 32'h0}, ax_q.size() ? ax_q.pop_front() : 'x);
   end

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ah, wh;
      ah = 1'b0;
      wh = 1'b0;
      ax_q.push_back({r, 32'h0});
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
      while (!(ah && wh)) begin
         @(posedge aclk);
         ah = ah | (s_axi_awvalid & s_axi_awready);
         wh = wh | (s_axi_wvalid & s_axi_wready);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [33:0] x);
      ax_q.push_back(x);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : axr

   // Kind bits: write, fetch, opcode, debug
   task automatic acc(input logic [3:0] k, input logic [15:0] a, input logic [7:0] wd);
      @(posedge aclk);
      {acc_valid, acc_write, acc_fetch, acc_opcode, acc_debug, acc_addr, acc_wdata} <= {1'b1, k, a, wd};
      @(posedge aclk);
      acc_valid <= 1'b0;
   endtask : acc

   // Vector bytes and three queue bytes come back as tagged reads, the new program counter before the queue bytes
   task automatic seq_note(input logic [15:0] v);
      logic [15:0] p;
      p = {u_mem.mem[v], u_mem.mem[v + 16'h1]};
      pc_q.push_back(34'(p));
      rd_q.push_back({2'b11, u_mem.mem[v]});
      rd_q.push_back({2'b11, u_mem.mem[v + 16'h1]});
      for (int k = 0; k < 3; k++) rd_q.push_back({2'b11, u_mem.mem[p + 16'(k)]});
   endtask : seq_note

   task automatic entry(input logic st, input logic [7:0] flg, input logic [15:0] v, input logic tk, ab);
      logic [15:0] pc;
      pc = {rnd, 8'h81};
      old = u_mem.mem[16'h20fc];
      if (!ab) lastv = {u_mem.mem[v], u_mem.mem[v + 16'h1]};
      if (tk) seq_note(ab ? RESET_VEC : v);
      @(posedge aclk);
      {core_pc, core_sp, core_x, core_a, condition_flags_register} <= {pc, 16'h2100, ~rnd, rnd ^ 8'h3c, flg};
      {soft_trap_instruction, irq_pending, irq_vector_addr, instr_boundary} <= {st, 1'b1, 16'hfff0, 1'b1};
      @(posedge aclk);
      instr_boundary <= 1'b0;
      if (ab) begin
         repeat (2) @(posedge aclk);
         por_event <= 1'b1;
         repeat (4) @(posedge aclk);
         chk(34'({core_hold, u_mem.mem[16'h20fc]}), 34'({1'b1, old}));
         por_event <= 1'b0;
      end
      if (tk) begin
         do @(posedge aclk); while (core_hold !== 1'b0);
      end else begin
         repeat (8) @(posedge aclk);
         chk(34'(core_hold), 34'(0));
      end
      {irq_pending, soft_trap_instruction} <= 2'b00;
      if (tk && !ab) begin
         chk(34'({u_mem.mem[16'h2100], u_mem.mem[16'h20ff], u_mem.mem[16'h20fe]}), 34'({pc[7:0], pc[15:8], ~rnd}));
         chk(34'({u_mem.mem[16'h20fd], u_mem.mem[16'h20fc], u_mem.mem[16'h2101]}), 34'({rnd ^ 8'h3c, flg, 8'h5b}));
      end
      rnd = lfsr(rnd);
   endtask : entry

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {core_x, core_a, condition_flags_register, acc_wdata, s_axi_wdata, secure_mode_in, por_event} = '0;
      {watchdog_timer_reset, instr_boundary, soft_trap_instruction, irq_pending, irq_vector_addr} = '0;
      {core_pc, core_sp, acc_addr, acc_valid, acc_write, acc_fetch, acc_opcode, acc_debug, aresetn} = '0;
      {reset_pin_n, reset_source_done, s_axi_wstrb, rnd} = {2'b00, 4'hf, 8'h11};
      repeat (4) @(posedge aclk);
      seq_note(RESET_VEC);
      aresetn <= 1'b1;
      repeat (12) @(posedge aclk);
      chk(34'(core_hold), 34'(1));
      reset_source_done <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(34'(core_hold), 34'(1));
      reset_pin_n <= 1'b1;
      do @(posedge aclk); while (core_hold !== 1'b0);
      axr(OFS_CTRL, 34'h1);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         {sm, tg, dbg, rg} = i[3:0];
         secure_mode_in <= sm;
         repeat (4) @(posedge aclk);
         ad = rg ? (dbg ? 16'h1820 : 16'h0030) : 16'h2000 + 16'(i);
         fa = tg ? 16'h3000 : 16'h0020;
         rd_q.push_back({1'b1, tg, u_mem.mem[fa]});
         acc(4'b0110, fa, 8'h00);
         rnd = lfsr(rnd);
         old = u_mem.mem[ad];
         ok = !sm || rg || (tg && !dbg);
         denies += ok ? 0 : 2;
         acc({3'b100, dbg}, ad, rnd);
         rd_q.push_back({2'b00, ok ? rnd : BLOCKED_DATA});
         acc({3'b000, dbg}, ad, 8'h00);
         repeat (3) @(posedge aclk);
         chk(34'(u_mem.mem[ad]), 34'(ok ? rnd : old));
      end
      axr(OFS_BLOCK_CNT, 34'(denies));
      axw(OFS_BLOCK_CNT, 32'h0, RESP_OKAY);
      axr(OFS_BLOCK_CNT, 34'h0);
      axw(8'h10, 32'h1, RESP_SLVERR);
      $display("test access gating done");
      rd_q.push_back({2'b10, u_mem.mem[16'h0020]});
      acc(4'b0110, 16'h0020, 8'h00);
      entry(1'b0, 8'h00, 16'hfff0, 1'b1, 1'b0);
      entry(1'b0, 8'h08, 16'hfff0, 1'b0, 1'b0);
      entry(1'b1, 8'h08, SOFT_TRAP_VEC, 1'b1, 1'b0);
      axr(OFS_LAST_VEC, 34'(lastv));
      axw(OFS_CTRL, 32'h0, RESP_OKAY);
      entry(1'b0, 8'h00, 16'hfff0, 1'b0, 1'b0);
      axw(OFS_CTRL, 32'h1, RESP_OKAY);
      chk(34'(imasks), 34'(2));
      entry(1'b1, 8'h04, SOFT_TRAP_VEC, 1'b1, 1'b1);
      $display("test interrupt and reset entry done");
      repeat (4) @(posedge aclk);
      end_of_test();
   end
endmodule : cps_core_seq_bench
